// ==== rwri_defs.svh ====
// constants for the reset and wake-up register block
`ifndef RWRI_DEFS_SVH
`define RWRI_DEFS_SVH

// register byte addresses
`define RWRI_OFF_CTRL 8'h00
`define RWRI_OFF_LATCH 8'h04
`define RWRI_OFF_DIR 8'h08
`define RWRI_OFF_PINS 8'h0c
`define RWRI_OFF_PFLAGS 8'h10
`define RWRI_OFF_INTCTL 8'h14
`define RWRI_OFF_PC 8'h18
`define RWRI_OFF_TOS 8'h1c
`define RWRI_OFF_RETURN_STACK_POINTER 8'h20
`define RWRI_OFF_STATUS 8'h24
`define RWRI_OFF_MASK 8'h28

// control register fields
`define RWRI_CTRL_OSC_LSB 0
`define RWRI_CTRL_STVR_BIT 3
`define RWRI_CTRL_LWE_BIT 4

// oscillator mode codes
`define RWRI_OSC_EXT_IO 3'h5
`define RWRI_OSC_RC_IO 3'h7

// interrupt control fields
`define RWRI_INT_GLOBAL_HIGH_IRQ_ENABLE_BIT 7
`define RWRI_INT_GLOBAL_LOW_IRQ_ENABLE_BIT 6
`define RWRI_INT_WDT_WAKE_BIT 0

// stack pointer register fields
`define RWRI_STK_FULL_BIT 7
`define RWRI_STK_UNF_BIT 6
`define RWRI_STK_TOP 5'h1f

// port a: gated bit and implemented mask
`define RWRI_PORT_GATED_BIT 6
`define RWRI_PORT_IMPL_MASK 8'h7f

// reset values
`define RWRI_DIR_RESET 8'h7f
`define RWRI_LATCH_RESET 8'h00
`define RWRI_CTRL_RESET 8'h08
`define RWRI_PC_RESET 21'h000000

// interrupt vectors
`define RWRI_VEC_HIGH 21'h000008
`define RWRI_VEC_LOW 21'h000018

// status event bits
`define RWRI_EV_POR 0
`define RWRI_EV_GROUP 1
`define RWRI_EV_WAKE 2
`define RWRI_EV_STACK 3

`endif

// ==== rwri_pkg.sv ====
// types for the reset and wake-up register block
package rwri_pkg;

  typedef logic [31:0][20:0] rwri_stack_type;

  typedef struct packed {
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [7:0] ctrl;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] pflags;
    logic [7:0] intctl;
    logic [20:0] pc;
    logic [4:0] sp;
    logic stk_full;
    logic stk_unf;
    rwri_stack_type stack_mem;
    logic [3:0] status;
    logic [3:0] mask;
    logic irq;
    logic [7:0] port_out;
    logic [7:0] port_oe;
    logic lwe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rwri_state_type;

endpackage

// ==== rwri_regs.sv ====
// reset and wake-up register initialisation block with an apb slave
// Behaviour
// R1 - wake-up sets an interrupt flag bit
// R2 - enabled interrupt wake loads matching vector
// R3 - enabled interrupt wake pushes pc on stack
// R4 - port bit 6 only in io oscillator modes
// R5 - long write enable cleared by por, master-clear only
// R6 - unimplemented bits always read zero
// R7 - group resets share one value set
// R8 - unchanged bits keep value through event
// R9 - stack fault flags then reset if enabled
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rwri_defs.svh"

module rwri_regs (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BROWNOUT,
  input wire logic MASTER_CLEAR,
  input wire logic WATCHDOG_RESET,
  input wire logic RESET_INSTR,
  input wire logic WAKE_WATCHDOG,
  input wire logic WAKE_IRQ,
  input wire logic WAKE_IRQ_HIGH,
  input wire logic [2:0] WAKE_IRQ_SRC,
  input wire logic STACK_PUSH,
  input wire logic STACK_POP,
  input wire logic [7:0] PORT_A_IN,
  output logic [7:0] PORT_A_OUT,
  output logic [7:0] PORT_A_OE,
  output logic LONG_WRITE_EN,
  output logic IRQ
);

  rwri_pkg::rwri_state_type r;
  rwri_pkg::rwri_state_type next_r;

  // mask for port a given the oscillator mode
  function automatic logic [7:0] port_mask(input logic [7:0] ctrl);
    logic [2:0] mode;
    logic [7:0] m;
    mode = ctrl[`RWRI_CTRL_OSC_LSB +: 3];
    m = `RWRI_PORT_IMPL_MASK;
    if (mode != `RWRI_OSC_EXT_IO && mode != `RWRI_OSC_RC_IO) begin
      m[`RWRI_PORT_GATED_BIT] = 1'b0;
    end
    return m;
  endfunction

  // widen a byte register to the bus word
  function automatic logic [31:0] word8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  // offsets that answer without a slave error
  function automatic logic addr_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      `RWRI_OFF_CTRL,
      `RWRI_OFF_LATCH,
      `RWRI_OFF_DIR,
      `RWRI_OFF_PINS,
      `RWRI_OFF_PFLAGS,
      `RWRI_OFF_INTCTL,
      `RWRI_OFF_PC,
      `RWRI_OFF_TOS,
      `RWRI_OFF_RETURN_STACK_POINTER,
      `RWRI_OFF_STATUS,
      `RWRI_OFF_MASK: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // R6 read mux, unused bits zero
  function automatic logic [31:0] read_word(
    input rwri_pkg::rwri_state_type s,
    input logic [7:0] addr,
    input logic [7:0] pm
  );
    logic [31:0] w;
    w = 32'h00000000;
    unique case (addr)
      `RWRI_OFF_CTRL: begin
        w = word8({3'h0, s.lwe, s.ctrl[3:0]});
      end
      `RWRI_OFF_LATCH: begin
        w = word8(s.latch & pm);
      end
      `RWRI_OFF_DIR: begin
        w = word8(s.dir & pm);
      end
      `RWRI_OFF_PINS: begin
        w = word8(s.pin_sync & pm);
      end
      `RWRI_OFF_PFLAGS: begin
        w = word8(s.pflags);
      end
      `RWRI_OFF_INTCTL: begin
        w = word8(s.intctl);
      end
      `RWRI_OFF_PC: begin
        w = {11'h000, s.pc};
      end
      `RWRI_OFF_TOS: begin
        w = {11'h000, s.stack_mem[s.sp]};
      end
      `RWRI_OFF_RETURN_STACK_POINTER: begin
        w = word8({s.stk_full, s.stk_unf, 1'b0, s.sp});
      end
      `RWRI_OFF_STATUS: begin
        w = {28'h0000000, s.status};
      end
      `RWRI_OFF_MASK: begin
        w = {28'h0000000, s.mask};
      end
      default: begin
        w = 32'h00000000;
      end
    endcase
    return w;
  endfunction

  // R3 push: pointer moves first, then the slot it points at is written
  function automatic rwri_pkg::rwri_state_type push_word(
    input rwri_pkg::rwri_state_type s,
    input logic [4:0] ptr,
    input logic [20:0] val
  );
    rwri_pkg::rwri_state_type t;
    logic [4:0] up;
    t = s;
    up = ptr + 5'h01;
    t.sp = up;
    t.stack_mem[up] = val;
    return t;
  endfunction

  // R7 values shared by the group resets and the power-on column
  function automatic rwri_pkg::rwri_state_type group_values(
    input rwri_pkg::rwri_state_type s
  );
    rwri_pkg::rwri_state_type t;
    // latch, stack flags, mask and control are left to the caller
    t = s;
    t.dir = `RWRI_DIR_RESET;
    t.pflags = 8'h00;
    t.intctl = 8'h00;
    t.pc = `RWRI_PC_RESET;
    t.sp = 5'h00;
    return t;
  endfunction

  logic [7:0] pmask;
  logic access;
  logic wr;
  logic rd;
  logic [3:0] ev;
  logic group_rst;
  logic por_rst;
  logic stack_fault;
  logic [31:0] rdata;
  logic mapped;

  always_comb begin
    next_r = r;
    pmask = port_mask(r.ctrl);
    access = PSEL & PENABLE & r.pready;
    wr = access & PWRITE;
    rd = access & ~PWRITE;
    ev = 4'h0;
    stack_fault = 1'b0;
    rdata = read_word(r, PADDR, pmask);
    mapped = addr_mapped(PADDR);

    next_r.pin_meta = PORT_A_IN;
    next_r.pin_sync = r.pin_meta;

    // apb: answer one cycle into the access phase
    next_r.pready = PSEL & PENABLE & ~r.pready;
    next_r.pslverr = PSEL & PENABLE & ~r.pready & ~mapped;
    if (PSEL & PENABLE & ~r.pready & ~PWRITE) begin
      next_r.prdata = rdata;
    end

    // software writes
    if (wr) begin
      unique case (PADDR)
        `RWRI_OFF_CTRL: begin
          next_r.ctrl = {4'h0, PWDATA[3:0]};
          next_r.lwe = PWDATA[`RWRI_CTRL_LWE_BIT];
        end
        // R4 gated bit written only when enabled
        `RWRI_OFF_LATCH: begin
          next_r.latch = PWDATA[7:0] & pmask;
        end
        `RWRI_OFF_DIR: begin
          next_r.dir = PWDATA[7:0] & pmask;
        end
        `RWRI_OFF_PFLAGS: begin
          next_r.pflags = PWDATA[7:0];
        end
        `RWRI_OFF_INTCTL: begin
          next_r.intctl = PWDATA[7:0];
        end
        `RWRI_OFF_PC: begin
          next_r.pc = PWDATA[20:0];
        end
        `RWRI_OFF_TOS: begin
          if (r.sp != 5'h00) begin
            next_r.stack_mem[r.sp] = PWDATA[20:0];
          end
        end
        `RWRI_OFF_RETURN_STACK_POINTER: begin
          // R9 flags only cleared by software
          next_r.stk_full = r.stk_full & PWDATA[`RWRI_STK_FULL_BIT];
          next_r.stk_unf = r.stk_unf & PWDATA[`RWRI_STK_UNF_BIT];
          next_r.sp = PWDATA[4:0];
        end
        `RWRI_OFF_MASK: begin
          next_r.mask = PWDATA[3:0];
        end
        default: begin
        end
      endcase
    end

    // core stack traffic
    if (STACK_PUSH) begin
      if (r.sp != `RWRI_STK_TOP) begin
        next_r = push_word(next_r, r.sp, r.pc);
      end
      // R9 full flag then reset if enabled
      if (r.sp >= (`RWRI_STK_TOP - 5'h01)) begin
        next_r.stk_full = 1'b1;
        stack_fault = r.ctrl[`RWRI_CTRL_STVR_BIT];
        ev[`RWRI_EV_STACK] = 1'b1;
      end
    end else if (STACK_POP) begin
      if (r.sp == 5'h00) begin
        // R9 underflow returns zero and flags
        next_r.pc = `RWRI_PC_RESET;
        next_r.stk_unf = 1'b1;
        stack_fault = r.ctrl[`RWRI_CTRL_STVR_BIT];
        ev[`RWRI_EV_STACK] = 1'b1;
      end else begin
        next_r.pc = r.stack_mem[r.sp];
        next_r.sp = r.sp - 5'h01;
      end
    end

    // wake-up from sleep; other state unchanged
    if (WAKE_WATCHDOG) begin
      // R1 record watchdog wake cause
      next_r.intctl[`RWRI_INT_WDT_WAKE_BIT] = 1'b1;
      ev[`RWRI_EV_WAKE] = 1'b1;
    end
    if (WAKE_IRQ) begin
      // R1 record interrupt wake cause
      next_r.pflags[WAKE_IRQ_SRC] = 1'b1;
      ev[`RWRI_EV_WAKE] = 1'b1;
      if ((WAKE_IRQ_HIGH & r.intctl[`RWRI_INT_GLOBAL_HIGH_IRQ_ENABLE_BIT]) |
          (~WAKE_IRQ_HIGH & r.intctl[`RWRI_INT_GLOBAL_LOW_IRQ_ENABLE_BIT])) begin
        // R2 vector by priority
        next_r.pc = WAKE_IRQ_HIGH ? `RWRI_VEC_HIGH : `RWRI_VEC_LOW;
        // R3 push current pc
        if (r.sp != `RWRI_STK_TOP) begin
          next_r = push_word(next_r, r.sp, r.pc);
        end else begin
          next_r.stk_full = 1'b1;
        end
      end
    end

    group_rst = MASTER_CLEAR | WATCHDOG_RESET | RESET_INSTR | stack_fault;
    por_rst = BROWNOUT;
    if (group_rst | por_rst) begin
      // R7 shared initial values
      next_r = group_values(next_r);
      // R8 latch, stack flags and control keep their values
      next_r.latch = r.latch;
      ev[`RWRI_EV_GROUP] = group_rst;
      ev[`RWRI_EV_WAKE] = 1'b0;
    end
    if (por_rst) begin
      // brown-out takes the power-on column
      next_r.latch = `RWRI_LATCH_RESET;
      next_r.ctrl = `RWRI_CTRL_RESET;
      ev[`RWRI_EV_POR] = 1'b1;
    end
    // R5 long write enable cleared by master-clear; brown-out and the other group resets keep it
    if (MASTER_CLEAR) begin
      next_r.lwe = 1'b0;
    end

    // sticky status: read clears, new event wins
    if (rd && PADDR == `RWRI_OFF_STATUS) begin
      // clear only the bits the read returned; a later event survives
      next_r.status = (r.status & ~r.prdata[3:0]) | ev;
    end else begin
      next_r.status = r.status | ev;
    end
    next_r.irq = |(next_r.status & next_r.mask);

    // R4 outputs follow the gating of the next mode
    next_r.port_out = next_r.latch & port_mask(next_r.ctrl);
    next_r.port_oe = ~next_r.dir & port_mask(next_r.ctrl);
  end

  // R5 power-on clears everything but ctrl, dir and status, including long write enable
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '0;
      r.ctrl <= `RWRI_CTRL_RESET;
      r.dir <= `RWRI_DIR_RESET;
      r.status <= 4'h1;
    end else begin
      r <= next_r;
    end
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign PORT_A_OUT = r.port_out;
  assign PORT_A_OE = r.port_oe;
  assign LONG_WRITE_EN = r.lwe;
  assign IRQ = r.irq;

endmodule
`default_nettype wire

// ==== rwri_regs_assertions.sv ====
// assertion checker for the reset and wake-up register block
`timescale 1ns/1ps
`default_nettype none
module rwri_regs_assertions (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BROWNOUT,
  input wire logic MASTER_CLEAR,
  input wire logic WATCHDOG_RESET,
  input wire logic RESET_INSTR,
  input wire logic [7:0] PORT_A_OUT,
  input wire logic [7:0] PORT_A_OE,
  input wire logic LONG_WRITE_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wire logic grp = MASTER_CLEAR | WATCHDOG_RESET | RESET_INSTR;
  a_ready_wait: assert property (PSEL && $rose(PENABLE) |=> PREADY)
    else $error("late ready");
  a_err_zero: assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0))
    else $error("error data");
  a_bit_seven: assert property (!PORT_A_OUT[7] && !PORT_A_OE[7])
    else $error("bit seven set");
  a_lwe_clear: assert property ($fell(LONG_WRITE_EN) |->
    $past(MASTER_CLEAR || (PSEL && PWRITE && PREADY))) else $error("lwe cleared");
  a_lwe_keep: assert property ((BROWNOUT || WATCHDOG_RESET || RESET_INSTR)
    && !MASTER_CLEAR && !PSEL |=> $stable(LONG_WRITE_EN)) else $error("lwe lost");
  a_group_dir: assert property (grp || BROWNOUT |-> ##[1:2] PORT_A_OE == 8'h00)
    else $error("dir not reset");
  a_latch_keep: assert property (grp && !BROWNOUT && !PSEL |=> $stable(PORT_A_OUT))
    else $error("latch lost");
  a_brown_latch: assert property (BROWNOUT |-> ##[1:2] PORT_A_OUT == 8'h00)
    else $error("latch kept");
endmodule
bind rwri_regs rwri_regs_assertions chk (.*);
`default_nettype wire

// ==== reset_and_wakeup_register_init_test.sv ====
// self-checking bench for the reset and wake-up register block
`timescale 1ns/1ps
`default_nettype none
`include "rwri_defs.svh"
module reset_and_wakeup_register_init_test;
  logic clk = '0, rst_n = '0, psel = '0, pen = '0, pwr = '0, hi = '0, er;
  logic [7:0] adr = '0, ev = '0, pins = 8'hff, pout, poe;
  logic [2:0] src = '0;
  logic [31:0] pwd = '0, prd, rd;
  logic prdy, perr, irq, lwe;
  int num_errors = 0, checks_done = 0, cyc = 0;
  rwri_regs uut (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(adr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .BROWNOUT(ev[0]), .MASTER_CLEAR(ev[1]), .WATCHDOG_RESET(ev[2]),
    .RESET_INSTR(ev[3]), .WAKE_WATCHDOG(ev[4]), .WAKE_IRQ(ev[5]), .WAKE_IRQ_HIGH(hi),
    .WAKE_IRQ_SRC(src), .STACK_PUSH(ev[6]), .STACK_POP(ev[7]), .PORT_A_IN(pins),
    .PORT_A_OUT(pout), .PORT_A_OE(poe), .LONG_WRITE_EN(lwe), .IRQ(irq));
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    adr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (prdy !== 1'h1);
    rd = prd;
    er = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 8'h00;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_reset;
    rc(`RWRI_OFF_DIR, 32'h3f);
    rc(`RWRI_OFF_STATUS, 32'h1);
    rc(8'h2c, 32'h0);
    chk(er, 1'h1);
  endtask
  task automatic t_port;
    logic [31:0] e;
    for (int m = 0; m < 8; m++) begin
      e = (m == 5 || m == 7) ? 32'h7f : 32'h3f;
      pins <= (m % 2 == 1) ? 8'hff : 8'h40;
      bus(1'h1, `RWRI_OFF_CTRL, 32'(m));
      bus(1'h1, `RWRI_OFF_LATCH, 32'hff);
      bus(1'h1, `RWRI_OFF_DIR, 32'h0);
      rc(`RWRI_OFF_LATCH, e);
      rc(`RWRI_OFF_PINS, {24'h0, pins} & e);
      chk(pout, e);
      chk(poe, e);
    end
  endtask
  task automatic t_lwe;
    bus(1'h1, `RWRI_OFF_CTRL, 32'h15);
    @(negedge clk);
    chk(lwe, 1'h1);
    for (int k = 2; k < 5; k++) begin
      pulse(8'h01 << k);
      chk(lwe, 1'h1);
    end
    chk(pout, 32'h7f);
    chk(poe, 32'h0);
    pulse(8'h01);
    chk(lwe, 1'h1);
    chk(pout, 32'h0);
    pulse(8'h02);
    chk(lwe, 1'h0);
  endtask
  task automatic t_wake;
    bus(1'h0, `RWRI_OFF_STATUS, 32'h0);
    bus(1'h1, `RWRI_OFF_MASK, 32'h4);
    bus(1'h1, `RWRI_OFF_INTCTL, 32'h80);
    bus(1'h1, `RWRI_OFF_PC, 32'h1234);
    hi <= 1'h1;
    src <= 3'h3;
    pulse(8'h20);
    chk(irq, 1'h1);
    rc(`RWRI_OFF_PC, 32'h8);
    rc(`RWRI_OFF_TOS, 32'h1234);
    rc(`RWRI_OFF_PFLAGS, 32'h8);
    rc(`RWRI_OFF_STATUS, 32'h4);
    bus(1'h1, `RWRI_OFF_INTCTL, 32'h40);
    hi <= 1'h0;
    pulse(8'h20);
    rc(`RWRI_OFF_PC, 32'h18);
    rc(`RWRI_OFF_TOS, 32'h8);
    bus(1'h1, `RWRI_OFF_INTCTL, 32'h0);
    pulse(8'h10);
    rc(`RWRI_OFF_INTCTL, 32'h1);
    rc(`RWRI_OFF_RETURN_STACK_POINTER, 32'h2);
  endtask
  task automatic t_stack;
    bus(1'h1, `RWRI_OFF_RETURN_STACK_POINTER, 32'h1e);
    pulse(8'h40);
    rc(`RWRI_OFF_RETURN_STACK_POINTER, 32'h80);
    bus(1'h1, `RWRI_OFF_RETURN_STACK_POINTER, 32'h0);
    pulse(8'h80);
    rc(`RWRI_OFF_RETURN_STACK_POINTER, 32'h40);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_reset;
    t_port;
    t_lwe;
    t_wake;
    t_stack;
    close_out;
  end
endmodule
`default_nettype wire
